// file: verilog/amsw_pkg.sv
// Constants shared by the routing switcher control logic.
// Assumes a single 100 MHz core clock; all times are turned into cycles here.
package amsw_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned HEARTBEAT_S = 6;
  localparam int unsigned HEARTBEAT_CYC = HEARTBEAT_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS = 5;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_MS = 50;
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);

  //////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ASSIGN = 8'h04;
  localparam logic [7:0] REG_BANK = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int unsigned CTRL_LONG_HAUL = 0;
  localparam int unsigned CTRL_REAMP = 1;
  localparam int unsigned CTRL_DIRECT_SRC = 2;
  localparam int unsigned CTRL_DIRECT_TAP = 3;
  localparam int unsigned CMD_STORE = 0;
  localparam int unsigned CMD_RECALL = 1;

  localparam int unsigned ST_IN_SEL = 0;
  localparam int unsigned ST_IN_MUTED = 2;
  localparam int unsigned ST_SYS_MUTE = 3;
  localparam int unsigned ST_OUT_SEL = 4;
  localparam int unsigned ST_BANK_MODE = 8;
  localparam int unsigned ST_REM_IN = 9;
  localparam int unsigned ST_REM_OUT = 10;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] ASSIGN_RST = 4'h0;
  localparam logic [3:0] BANK_RST = 4'h1;
  localparam logic [3:0] OUT_SEL_RST = 4'h1;
  localparam logic [1:0] IN_SEL_RST = 2'h0;

  // Positions in the debounced button vector.
  localparam int unsigned BTN_IN = 0;
  localparam int unsigned BTN_OUT = 4;
  localparam int unsigned BTN_MUTE = 8;
  localparam int unsigned BTN_BANK = 9;
  localparam int unsigned BTN_FSW = 10;
  localparam int unsigned BTN_RIN = 11;
  localparam int unsigned BTN_RIN_MUTE = 15;
  localparam int unsigned BTN_ROUT = 16;
  localparam int unsigned BTN_ROUT_MUTE = 20;
  localparam int unsigned BTN_ROUT_BANK = 21;
  localparam int unsigned BTN_RIN_PRES = 22;
  localparam int unsigned BTN_ROUT_PRES = 23;
  localparam int unsigned BTN_COUNT = 24;

  typedef enum logic {
    AMSW_ROUTED = 1'b0,
    AMSW_MUTED = 1'b1
  } amsw_in_state_t;

endpackage

// file: verilog/amsw_debounce.sv
// Synchroniser and debouncer for a vector of switch contacts.
// Assumes contacts are high while closed; a press pulse marks each closure.
`timescale 1ns/1ps
module amsw_debounce #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STABLE_CYC = amsw_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] press
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // A contact must hold its new level for the whole window before it counts.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic [CW-1:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_q <= '0;
        level[i] <= 1'b0;
        press[i] <= 1'b0;
      end
      else
      begin
        press[i] <= 1'b0;
        if (sync2_q[i] == level[i])
          cnt_q <= '0;
        else if (cnt_q == LAST)
        begin
          cnt_q <= '0;
          level[i] <= sync2_q[i];
          press[i] <= sync2_q[i]; // RULE_22
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // amsw_debounce

// file: verilog/amsw_timebase.sv
// Common timebase for the heartbeat flashes and the selection confirmation flash.
// Assumes confirm is a one-cycle pulse; a new pulse restarts the flash.
`timescale 1ns/1ps
module amsw_timebase #(
  parameter int unsigned PERIOD = amsw_pkg::HEARTBEAT_CYC,
  parameter int unsigned HOLD = amsw_pkg::FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic confirm,
  output logic beat,
  output logic ack
);
  localparam int unsigned PW = $clog2(PERIOD + 1);
  localparam int unsigned HW = $clog2(HOLD + 1);
  localparam logic [PW-1:0] P_LAST = PW'(PERIOD - 1);
  localparam logic [HW-1:0] H_LOAD = HW'(HOLD);

  logic [PW-1:0] per_q;
  logic [HW-1:0] beat_q;
  logic [HW-1:0] ack_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_q <= '0;
      beat_q <= '0;
    end
    else if (per_q == P_LAST)
    begin
      per_q <= '0;
      beat_q <= H_LOAD; // RULE_23
    end
    else
    begin
      per_q <= per_q + 1'b1;
      if (beat_q != '0)
        beat_q <= beat_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= '0;
    else if (confirm)
      ack_q <= H_LOAD; // RULE_23
    else if (ack_q != '0)
      ack_q <= ack_q - 1'b1;
  end

  assign beat = (beat_q != '0);
  assign ack = (ack_q != '0);
endmodule // amsw_timebase

// file: verilog/amsw_top.sv
// Routing switcher control: input/output selection, mute, banks, indicators.
// Assumes buttons and footswitch contacts are high while closed and APB is
// clocked by CORE_CLK.
//
// Summary of operation
// RULE_01: Only one instrument input routed at once.
// RULE_02: Second press mutes input; next press restores.
// RULE_03: Any output combination; LED per selected output.
// RULE_04: Bank stores output combination; one press recalls.
// RULE_05: Input heartbeat flashes every six seconds.
// RULE_06: Input heartbeat flashes on accepted selection.
// RULE_07: Output heartbeat flashes; steady in bank mode.
// RULE_08: Signal LED lights on detected input signal.
// RULE_09: Long-haul loop LED lit while loop enabled.
// RULE_10: Reamp LED lit; receive input becomes source.
// RULE_11: Loop LED needs an assigned enabled output.
// RULE_12: Mute kills outputs and loops, lights LED.
// RULE_13: Tuner feed always enabled.
// RULE_14: Panel button and footswitch toggle one mute.
// RULE_15: Mute footswitch is momentary, normally open.
// RULE_16: Two remote ports, auto-recognised when attached.
// RULE_17: Input remote selects/mutes; output remote selects/mutes.
// RULE_18: Remote LEDs mirror front-panel LEDs.
// RULE_19: Direct source: all inputs, or fourth only.
// RULE_20: Direct tap: before loop outward, after inward.
// RULE_21: Power-up routes first input to first output.
// RULE_22: Contacts synchronised and debounced, one event each.
// RULE_23: Flashes come from a common timebase.
`timescale 1ns/1ps
module amsw_top #(
  parameter int unsigned HEARTBEAT_CYC = amsw_pkg::HEARTBEAT_CYC,
  parameter int unsigned DEBOUNCE_CYC = amsw_pkg::DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYC = amsw_pkg::FLASH_CYC
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] PANEL_IN_BTN,
  input wire logic [3:0] PANEL_OUT_BTN,
  input wire logic PANEL_MUTE_BTN,
  input wire logic PANEL_BANK_BTN,
  input wire logic MUTE_FSW,
  input wire logic REM_IN_PRESENT,
  input wire logic [3:0] REM_IN_BTN,
  input wire logic REM_IN_MUTE_BTN,
  input wire logic REM_OUT_PRESENT,
  input wire logic [3:0] REM_OUT_BTN,
  input wire logic REM_OUT_MUTE_BTN,
  input wire logic REM_OUT_BANK_BTN,
  input wire logic SIGNAL_DET,
  output logic [3:0] IN_ROUTE_EN,
  output logic [3:0] IN_LED,
  output logic [3:0] OUT_EN,
  output logic [3:0] OUT_LED,
  output logic TUNER_EN,
  output logic MUTE_LED,
  output logic LOCAL_EFFECTS_LOOP_EN,
  output logic LOCAL_EFFECTS_LOOP_LED,
  output logic LONG_HAUL_LOOP_EN,
  output logic LONG_HAUL_LOOP_INDICATOR,
  output logic REAMP_EN,
  output logic REAMP_LED,
  output logic SIGNAL_LED,
  output logic IN_HEARTBEAT_LED,
  output logic OUT_HEARTBEAT_LED,
  output logic [3:0] DIRECT_SRC_EN,
  output logic DIRECT_TAP_POST,
  output logic [3:0] REM_IN_LED,
  output logic REM_IN_MUTE_LED,
  output logic [3:0] REM_OUT_LED,
  output logic REM_OUT_MUTE_LED
);
  localparam int unsigned NB = amsw_pkg::BTN_COUNT;

  logic [NB-1:0] raw;
  logic [NB-1:0] lvl;
  logic [NB-1:0] prs;
  logic rem_in;
  logic rem_out;
  logic [3:0] in_press;
  logic [3:0] out_press;
  logic in_mute_press;
  logic sys_mute_press;
  logic bank_press;
  logic [1:0] in_sel_q;
  amsw_pkg::amsw_in_state_t in_state_q;
  logic confirm_q;
  logic sys_mute_q;
  logic [3:0] out_sel_q;
  logic bank_mode_q;
  logic [3:0] ctrl_q;
  logic [3:0] assign_q;
  logic [3:0] bank_q;
  logic beat;
  logic ack;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rdata;
  logic [3:0] in_onehot;

  //////////////////////////////////////////////////////////////////////////////
  // Contacts: every button, footswitch and remote presence line is filtered.
  assign raw = {REM_OUT_PRESENT, REM_IN_PRESENT, REM_OUT_BANK_BTN, REM_OUT_MUTE_BTN,
                REM_OUT_BTN, REM_IN_MUTE_BTN, REM_IN_BTN, MUTE_FSW, PANEL_BANK_BTN,
                PANEL_MUTE_BTN, PANEL_OUT_BTN, PANEL_IN_BTN};

  amsw_debounce #(
    .WIDTH(NB),
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .raw(raw),
    .level(lvl),
    .press(prs)
  );

  // A remote counts as attached once its presence line is steady; its
  // buttons are ignored until then so a half-seated plug cannot glitch.
  assign rem_in = lvl[amsw_pkg::BTN_RIN_PRES]; // RULE_16
  assign rem_out = lvl[amsw_pkg::BTN_ROUT_PRES]; // RULE_16

  assign in_press = prs[amsw_pkg::BTN_IN +: 4] |
                    (prs[amsw_pkg::BTN_RIN +: 4] & {4{rem_in}}); // RULE_17
  assign out_press = prs[amsw_pkg::BTN_OUT +: 4] |
                     (prs[amsw_pkg::BTN_ROUT +: 4] & {4{rem_out}}); // RULE_17
  assign in_mute_press = prs[amsw_pkg::BTN_RIN_MUTE] & rem_in; // RULE_17
  // The footswitch is momentary, so only its closing edge is an event.
  assign sys_mute_press = prs[amsw_pkg::BTN_MUTE] | prs[amsw_pkg::BTN_FSW] |
                          (prs[amsw_pkg::BTN_ROUT_MUTE] & rem_out); // RULE_14 RULE_15
  assign bank_press = prs[amsw_pkg::BTN_BANK] |
                      (prs[amsw_pkg::BTN_ROUT_BANK] & rem_out); // RULE_04

  //////////////////////////////////////////////////////////////////////////////
  // Input selection. Simultaneous presses go to the lowest input other than the one already selected.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      in_sel_q <= amsw_pkg::IN_SEL_RST; // RULE_21
      in_state_q <= amsw_pkg::AMSW_ROUTED;
      confirm_q <= 1'b0;
    end
    else
    begin
      confirm_q <= 1'b0;
      if (in_press != 4'h0)
      begin
        confirm_q <= 1'b1; // RULE_06
        for (int i = 3; i >= 0; i--)
        begin
          if (in_press[i])
          begin
            if (in_sel_q == 2'(i))
            begin
              unique case (in_state_q)
                amsw_pkg::AMSW_ROUTED: in_state_q <= amsw_pkg::AMSW_MUTED; // RULE_02
                amsw_pkg::AMSW_MUTED: in_state_q <= amsw_pkg::AMSW_ROUTED; // RULE_02
              endcase
            end
            else
            begin
              in_sel_q <= 2'(i); // RULE_01
              in_state_q <= amsw_pkg::AMSW_ROUTED; // RULE_02
            end
          end
        end
      end
      else if (in_mute_press)
      begin
        unique case (in_state_q)
          amsw_pkg::AMSW_ROUTED: in_state_q <= amsw_pkg::AMSW_MUTED; // RULE_17
          amsw_pkg::AMSW_MUTED: in_state_q <= amsw_pkg::AMSW_ROUTED; // RULE_17
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      sys_mute_q <= 1'b0;
    else if (sys_mute_press)
      sys_mute_q <= !sys_mute_q; // RULE_14
  end

  // Output selection. A bank recall replaces the whole combination; a manual
  // press leaves bank mode, since the set no longer matches the bank.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      out_sel_q <= amsw_pkg::OUT_SEL_RST; // RULE_21
      bank_mode_q <= 1'b0;
    end
    else if (bank_press || (wr && PADDR == amsw_pkg::REG_CMD &&
                            PWDATA[amsw_pkg::CMD_RECALL]))
    begin
      out_sel_q <= bank_q; // RULE_04
      bank_mode_q <= 1'b1;
    end
    else if (out_press != 4'h0)
    begin
      out_sel_q <= out_sel_q ^ out_press; // RULE_03
      bank_mode_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped addresses.
  assign wr = PSEL && PENABLE && PWRITE && hit;
  assign rd = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h0;
    unique case (PADDR)
      amsw_pkg::REG_CTRL: rdata[3:0] = ctrl_q;
      amsw_pkg::REG_ASSIGN: rdata[3:0] = assign_q;
      amsw_pkg::REG_BANK: rdata[3:0] = bank_q;
      amsw_pkg::REG_CMD: rdata = 32'h0;
      amsw_pkg::REG_STATUS:
      begin
        rdata[amsw_pkg::ST_IN_SEL +: 2] = in_sel_q;
        rdata[amsw_pkg::ST_IN_MUTED] = (in_state_q == amsw_pkg::AMSW_MUTED);
        rdata[amsw_pkg::ST_SYS_MUTE] = sys_mute_q;
        rdata[amsw_pkg::ST_OUT_SEL +: 4] = out_sel_q;
        rdata[amsw_pkg::ST_BANK_MODE] = bank_mode_q;
        rdata[amsw_pkg::ST_REM_IN] = rem_in;
        rdata[amsw_pkg::ST_REM_OUT] = rem_out;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      PRDATA <= 32'h0;
    else if (rd && !PENABLE)
      PRDATA <= rdata;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_q <= amsw_pkg::CTRL_RST;
      assign_q <= amsw_pkg::ASSIGN_RST;
    end
    else if (wr && PADDR == amsw_pkg::REG_CTRL)
      ctrl_q <= PWDATA[3:0];
    else if (wr && PADDR == amsw_pkg::REG_ASSIGN)
      assign_q <= PWDATA[3:0]; // RULE_11
  end

  // Store takes the live output set; a direct write sets any combination.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      bank_q <= amsw_pkg::BANK_RST;
    else if (wr && PADDR == amsw_pkg::REG_BANK)
      bank_q <= PWDATA[3:0]; // RULE_04
    else if (wr && PADDR == amsw_pkg::REG_CMD && PWDATA[amsw_pkg::CMD_STORE])
      bank_q <= out_sel_q; // RULE_04
  end

  //////////////////////////////////////////////////////////////////////////////
  amsw_timebase #(
    .PERIOD(HEARTBEAT_CYC),
    .HOLD(FLASH_CYC)
  ) u_timebase (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .confirm(confirm_q),
    .beat(beat),
    .ack(ack)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Drive stage: every pin is registered so relays never see decode glitches.
  assign in_onehot = 4'h1 << in_sel_q;

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      IN_ROUTE_EN <= 4'h0;
      IN_LED <= 4'h0;
      OUT_EN <= 4'h0;
      OUT_LED <= 4'h0;
      TUNER_EN <= 1'b1;
      MUTE_LED <= 1'b0;
      LOCAL_EFFECTS_LOOP_EN <= 1'b0;
      LOCAL_EFFECTS_LOOP_LED <= 1'b0;
      LONG_HAUL_LOOP_EN <= 1'b0;
      LONG_HAUL_LOOP_INDICATOR <= 1'b0;
      REAMP_EN <= 1'b0;
      REAMP_LED <= 1'b0;
      SIGNAL_LED <= 1'b0;
      IN_HEARTBEAT_LED <= 1'b0;
      OUT_HEARTBEAT_LED <= 1'b0;
      DIRECT_SRC_EN <= 4'hf;
      DIRECT_TAP_POST <= 1'b1;
      REM_IN_LED <= 4'h0;
      REM_IN_MUTE_LED <= 1'b0;
      REM_OUT_LED <= 4'h0;
      REM_OUT_MUTE_LED <= 1'b0;
    end
    else
    begin
      IN_ROUTE_EN <= (in_state_q == amsw_pkg::AMSW_ROUTED) ? in_onehot : 4'h0; // RULE_01
      IN_LED <= (in_state_q == amsw_pkg::AMSW_ROUTED) ? in_onehot : 4'h0; // RULE_21
      OUT_EN <= sys_mute_q ? 4'h0 : out_sel_q; // RULE_12
      OUT_LED <= out_sel_q; // RULE_03
      TUNER_EN <= 1'b1; // RULE_13
      MUTE_LED <= sys_mute_q; // RULE_12
      LOCAL_EFFECTS_LOOP_EN <= !sys_mute_q && ((out_sel_q & assign_q) != 4'h0); // RULE_12
      LOCAL_EFFECTS_LOOP_LED <= !sys_mute_q && ((out_sel_q & assign_q) != 4'h0); // RULE_11
      // With the long-haul loop on, an unconnected loop leaves the path silent.
      LONG_HAUL_LOOP_EN <= ctrl_q[amsw_pkg::CTRL_LONG_HAUL] && !sys_mute_q; // RULE_09
      LONG_HAUL_LOOP_INDICATOR <= ctrl_q[amsw_pkg::CTRL_LONG_HAUL]; // RULE_09
      REAMP_EN <= ctrl_q[amsw_pkg::CTRL_REAMP]; // RULE_10
      REAMP_LED <= ctrl_q[amsw_pkg::CTRL_REAMP]; // RULE_10
      SIGNAL_LED <= SIGNAL_DET && (in_state_q == amsw_pkg::AMSW_ROUTED); // RULE_08
      IN_HEARTBEAT_LED <= beat || ack; // RULE_05 RULE_06
      OUT_HEARTBEAT_LED <= bank_mode_q || beat; // RULE_07
      DIRECT_SRC_EN <= ctrl_q[amsw_pkg::CTRL_DIRECT_SRC] ? 4'h8 : 4'hf; // RULE_19
      DIRECT_TAP_POST <= !ctrl_q[amsw_pkg::CTRL_DIRECT_TAP]; // RULE_20
      REM_IN_LED <= rem_in && (in_state_q == amsw_pkg::AMSW_ROUTED) ?
                    in_onehot : 4'h0; // RULE_18
      REM_IN_MUTE_LED <= rem_in && (in_state_q == amsw_pkg::AMSW_MUTED); // RULE_18
      REM_OUT_LED <= rem_out ? out_sel_q : 4'h0; // RULE_18
      REM_OUT_MUTE_LED <= rem_out && sys_mute_q; // RULE_18
    end
  end
endmodule // amsw_top

// file: test/amsw_chk.sv
// Pin-level checker for the routing switcher top, attached by bind.
// Assumes the bench runs the short simulation counts.
`timescale 1ns/1ps
module amsw_chk #(
  parameter int unsigned HEARTBEAT_CYC = 200
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic SIGNAL_DET,
  input wire logic [3:0] IN_ROUTE_EN,
  input wire logic [3:0] IN_LED,
  input wire logic [3:0] OUT_EN,
  input wire logic [3:0] OUT_LED,
  input wire logic TUNER_EN,
  input wire logic MUTE_LED,
  input wire logic LOCAL_EFFECTS_LOOP_EN,
  input wire logic LOCAL_EFFECTS_LOOP_LED,
  input wire logic LONG_HAUL_LOOP_EN,
  input wire logic REAMP_EN,
  input wire logic REAMP_LED,
  input wire logic SIGNAL_LED,
  input wire logic IN_HEARTBEAT_LED,
  input wire logic OUT_HEARTBEAT_LED,
  input wire logic [3:0] DIRECT_SRC_EN,
  input wire logic REM_OUT_MUTE_LED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////
  // A stuck heartbeat shows only as a long dark stretch, so count it.
  logic [31:0] dark_q;
  always_ff @(posedge CORE_CLK or negedge ARST_N)
    if (!ARST_N)
      dark_q <= 32'h0;
    else
      dark_q <= IN_HEARTBEAT_LED ? 32'h0 : dark_q + 32'h1;
  ////////////////////////////////////////////////////////////
  chk_tuner_on: assert property (TUNER_EN)
    else $error("tuner feed dropped");
  chk_one_input: assert property ($onehot0(IN_ROUTE_EN) && IN_LED == IN_ROUTE_EN)
    else $error("more than one input routed");
  chk_mute_cuts: assert property (MUTE_LED |-> OUT_EN == 4'h0 && !LOCAL_EFFECTS_LOOP_EN
    && !LONG_HAUL_LOOP_EN)
    else $error("output live during mute");
  chk_out_follows: assert property (!MUTE_LED |-> OUT_EN == OUT_LED)
    else $error("output relay differs from its lamp");
  chk_loop_lamp: assert property (LOCAL_EFFECTS_LOOP_LED |-> OUT_EN != 4'h0
    && LOCAL_EFFECTS_LOOP_EN)
    else $error("loop lamp without an enabled output");
  chk_reamp_lamp: assert property (REAMP_LED == REAMP_EN)
    else $error("reamp lamp differs from reamp path");
  chk_signal_lamp: assert property (SIGNAL_LED |-> $past(SIGNAL_DET) && IN_ROUTE_EN != 4'h0)
    else $error("signal lamp without detected signal");
  chk_beat_gap: assert property (dark_q <= HEARTBEAT_CYC)
    else $error("heartbeat missing");
  chk_direct_src: assert property (DIRECT_SRC_EN == 4'hf || DIRECT_SRC_EN == 4'h8)
    else $error("bad direct source set");
  chk_remote_mute: assert property (REM_OUT_MUTE_LED |-> MUTE_LED)
    else $error("remote mute lamp differs");
  cover property (MUTE_LED && OUT_LED != 4'h0);
  cover property (LOCAL_EFFECTS_LOOP_LED);
  cover property (OUT_HEARTBEAT_LED [*8]);
endmodule // amsw_chk

bind amsw_top amsw_chk #(.HEARTBEAT_CYC(HEARTBEAT_CYC)) amsw_chk_i (.*);

// file: test/amsw_panel.sv
// Model of the panel buttons, mute footswitch and remote units.
// Assumes the bench calls press and plug from just after a rising edge.
`timescale 1ns/1ps
module amsw_panel #(
  parameter int unsigned DEB = 4
) (
  input wire logic clk,
  output logic [23:0] sw
);
  // Whole-vector updates keep every contact visibly driven by this model.
  logic [23:0] closed_q = 24'h000000;
  assign sw = closed_q;
  // Contacts chatter before closing; that chatter must not count as a press.
  task automatic press(input int unsigned p);
    logic [23:0] m;
    m = 24'h000001 << p;
    closed_q <= closed_q | m;
    @(posedge clk);
    closed_q <= closed_q & ~m;
    @(posedge clk);
    closed_q <= closed_q | m;
    repeat (DEB + 6) @(posedge clk);
    closed_q <= closed_q & ~m;
    repeat (DEB + 6) @(posedge clk);
  endtask
  task automatic plug(input int unsigned p);
    closed_q <= closed_q | (24'h000001 << p);
    repeat (DEB + 6) @(posedge clk);
  endtask
endmodule // amsw_panel

// file: test/amsw_top_tb.sv
// Self-checking bench for the routing switcher control.
// Assumes the short counts below; the switch model drives all contacts.
`timescale 1ns/1ps
module amsw_top_tb;
  localparam int unsigned HB = 200;
  localparam int unsigned DB = 4;
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic SIGNAL_DET = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, er;
  logic [23:0] sw;
  logic [3:0] IN_ROUTE_EN, IN_LED, OUT_EN, OUT_LED, DIRECT_SRC_EN, REM_IN_LED, REM_OUT_LED;
  logic TUNER_EN, MUTE_LED, LOCAL_EFFECTS_LOOP_EN, LOCAL_EFFECTS_LOOP_LED, LONG_HAUL_LOOP_EN;
  logic LONG_HAUL_LOOP_INDICATOR, REAMP_EN, REAMP_LED, SIGNAL_LED, IN_HEARTBEAT_LED;
  logic OUT_HEARTBEAT_LED, DIRECT_TAP_POST, REM_IN_MUTE_LED, REM_OUT_MUTE_LED;
  int miscompares = 0;
  int n_checks = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  amsw_panel #(.DEB(DB)) amsw_panel_i (.clk(CORE_CLK), .sw(sw));
  amsw_top #(.HEARTBEAT_CYC(HB), .DEBOUNCE_CYC(DB), .FLASH_CYC(10)) amsw_top_i (
    .PANEL_IN_BTN(sw[3:0]), .PANEL_OUT_BTN(sw[7:4]), .PANEL_MUTE_BTN(sw[8]),
    .PANEL_BANK_BTN(sw[9]), .MUTE_FSW(sw[10]), .REM_IN_BTN(sw[14:11]),
    .REM_IN_MUTE_BTN(sw[15]), .REM_OUT_BTN(sw[19:16]), .REM_OUT_MUTE_BTN(sw[20]),
    .REM_OUT_BANK_BTN(sw[21]), .REM_IN_PRESENT(sw[22]), .REM_OUT_PRESENT(sw[23]), .*);
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input logic [63:0] g, input logic [63:0] x);
    n_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Request is held until PREADY is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        miscompares++;
        tally_and_finish();
      end
      @(posedge CORE_CLK);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_inputs();
    fork
      amsw_panel_i.press(2);
      begin
        repeat (DB + 9) @(posedge CORE_CLK);
        ck(IN_HEARTBEAT_LED, 1);
      end
    join
    ck(IN_ROUTE_EN, 4'h4);
    amsw_panel_i.press(2);
    ck(IN_ROUTE_EN, 4'h0);
    amsw_panel_i.press(2);
    ck(IN_ROUTE_EN, 4'h4);
    amsw_panel_i.press(3);
    amsw_panel_i.press(3);
    amsw_panel_i.press(1);
    ck(IN_LED, 4'h2);
  endtask
  task automatic t_outs_mute();
    amsw_panel_i.press(5);
    amsw_panel_i.press(6);
    ck(OUT_EN, 4'h7);
    amsw_panel_i.press(4);
    ck(OUT_LED, 4'h6);
    amsw_panel_i.press(8);
    ck({MUTE_LED, TUNER_EN, OUT_EN, OUT_LED}, 10'h306);
    amsw_panel_i.press(10);
    ck({MUTE_LED, OUT_EN}, 5'h06);
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    ck(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    ck(rd, 32'h1);
    apb(1'b1, 8'h04, 32'h2);
    ck(LOCAL_EFFECTS_LOOP_LED, 1);
    apb(1'b1, 8'h04, 32'h1);
    ck(LOCAL_EFFECTS_LOOP_LED, 0);
    apb(1'b1, 8'h00, 32'hf);
    ck({LONG_HAUL_LOOP_INDICATOR, REAMP_LED, DIRECT_SRC_EN, DIRECT_TAP_POST}, 7'h70);
    apb(1'b1, 8'h00, 32'h0);
    ck({LONG_HAUL_LOOP_INDICATOR, DIRECT_SRC_EN, DIRECT_TAP_POST}, 6'h1f);
    apb(1'b0, 8'h20, 32'h0);
    ck({er, rd}, 33'h100000000);
  endtask
  task automatic t_bank();
    int lo;
    lo = 0;
    apb(1'b1, 8'h0c, 32'h1);
    amsw_panel_i.press(7);
    amsw_panel_i.press(9);
    ck(OUT_EN, 4'h6);
    repeat (HB + 20)
    begin
      @(posedge CORE_CLK);
      lo += (OUT_HEARTBEAT_LED !== 1'b1);
    end
    ck(lo, 0);
    amsw_panel_i.press(4);
    apb(1'b1, 8'h0c, 32'h2);
    ck({OUT_EN, OUT_HEARTBEAT_LED}, 5'h0d);
  endtask
  task automatic t_remote();
    amsw_panel_i.press(13);
    ck(IN_ROUTE_EN, 4'h2);
    amsw_panel_i.plug(22);
    amsw_panel_i.plug(23);
    amsw_panel_i.press(14);
    ck({IN_ROUTE_EN, REM_IN_LED}, 8'h88);
    amsw_panel_i.press(15);
    ck({IN_ROUTE_EN, REM_IN_MUTE_LED}, 5'h01);
    amsw_panel_i.press(19);
    ck({OUT_EN, REM_OUT_LED}, 8'hee);
    amsw_panel_i.press(20);
    ck({MUTE_LED, REM_OUT_MUTE_LED}, 2'h3);
    amsw_panel_i.press(20);
    ck(MUTE_LED, 0);
  endtask
  task automatic t_monitor();
    int hi;
    hi = 0;
    SIGNAL_DET <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    ck(SIGNAL_LED, 0);
    amsw_panel_i.press(15);
    ck(SIGNAL_LED, 1);
    repeat (2 * HB)
    begin
      @(posedge CORE_CLK);
      hi += (IN_HEARTBEAT_LED === 1'b1);
    end
    ck(hi > 0, 1);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    ck({TUNER_EN, IN_ROUTE_EN, IN_LED, OUT_EN, OUT_LED}, 17'h11111);
    t_inputs();
    t_outs_mute();
    t_regs();
    t_bank();
    t_remote();
    t_monitor();
    tally_and_finish();
  end
endmodule // amsw_top_tb
